// >>> core/tps_port.sv
// Test port with controller select and shared return clock pin
`timescale 1ns/1ps
module tps_port
  import tps_pkg::*;
#(
  parameter logic [31:0] ID_VALUE = TPS_ID_DEF
)
(
  input  logic        CLK,
  input  logic        RST,
  input  logic        TCK,
  input  logic        TMS,
  input  logic        TDI,
  input  logic        TRST_N,
  input  logic        CTRL_SEL,
  input  logic        FACT_TDO,
  input  logic        RET_CLK_MODE,
  input  logic        WIRE_O,
  input  logic        WIRE_OE,
  input  logic        SHARE_I,
  input  logic [31:0] USER_DIN,
  output logic        TDO,
  output logic        TDO_OE,
  output logic        SHARE_O,
  output logic        SHARE_OE,
  output logic        WIRE_RX,
  output logic        DBG_SEL,
  output logic [31:0] USER_DOUT
);

  logic        tck_s1_q, tck_s2_q, tck_s3_q;
  logic        tms_s1_q, tms_s2_q, tdi_s1_q, tdi_s2_q;
  logic        sel_s1_q, sel_s2_q, shr_s1_q, shr_s2_q;
  logic [1:0]  rel_q;
  logic        rel_prev_q;
  logic        trst_any;
  logic        tap_rst;
  logic        tck_rise;
  logic        tck_fall;
  logic        trst_rel;
  tps_state_t  state_q;
  logic [3:0]  ir_sh_q, ir_sh_d, ir_q, ir_d;
  logic [31:0] dr_sh_q, dr_sh_d, user_q, user_d;
  logic        sel_q, sel_d;
  logic        tdo_q, tdo_d, tdo_oe_q, tdo_oe_d;
  logic        shr_o_q, shr_o_d, shr_oe_q, shr_oe_d;
  logic        wrx_q, wrx_d;

  // Pin synchronisers and test clock edge detect
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      tck_s1_q <= 1'b0;
      tck_s2_q <= 1'b0;
      tck_s3_q <= 1'b0;
      tms_s1_q <= 1'b1;
      tms_s2_q <= 1'b1;
      tdi_s1_q <= 1'b1;
      tdi_s2_q <= 1'b1;
      sel_s1_q <= TPS_SEL_RST;
      sel_s2_q <= TPS_SEL_RST;
      shr_s1_q <= 1'b1;
      shr_s2_q <= 1'b1;
      rel_prev_q <= 1'b0;
    end else begin
      tck_s1_q <= TCK;
      tck_s2_q <= tck_s1_q;
      tck_s3_q <= tck_s2_q;
      tms_s1_q <= TMS;
      tms_s2_q <= tms_s1_q;
      tdi_s1_q <= TDI;
      tdi_s2_q <= tdi_s1_q;
      sel_s1_q <= CTRL_SEL;
      sel_s2_q <= sel_s1_q;
      shr_s1_q <= SHARE_I;
      shr_s2_q <= shr_s1_q;
      rel_prev_q <= rel_q[1];
    end
  end

  assign tck_rise = tck_s2_q & ~tck_s3_q;
  assign tck_fall = ~tck_s2_q & tck_s3_q;

  // Test reset asserts at once and releases after two clocks
  assign trst_any = RST | ~TRST_N;
  always_ff @(posedge CLK or posedge trst_any) begin
    if (trst_any) begin
      rel_q <= 2'b00;
    end else begin
      rel_q <= {rel_q[0], 1'b1};
    end
  end
  assign tap_rst  = RST | ~rel_q[1];
  assign trst_rel = rel_q[1] & ~rel_prev_q;

  tps_tap_fsm u_fsm (
    .clk     (CLK),
    .rst     (tap_rst),
    .adv     (tck_rise),
    .tms     (tms_s2_q),
    .state_q (state_q)
  );

  // Instruction and data shifting on test clock rise
  always_comb begin
    ir_sh_d = ir_sh_q;
    ir_d    = ir_q;
    dr_sh_d = dr_sh_q;
    user_d  = user_q;
    if (state_q == TPS_TLR) begin
      ir_d = TPS_IR_IDCODE;
    end
    if (tck_rise) begin
      case (state_q)
        TPS_CAP_IR: ir_sh_d = TPS_IR_CAPT;
        TPS_SHF_IR: ir_sh_d = {tdi_s2_q, ir_sh_q[3:1]};
        TPS_UPD_IR: ir_d = ir_sh_q;
        TPS_CAP_DR: begin
          case (ir_q)
            TPS_IR_IDCODE: dr_sh_d = ID_VALUE;
            TPS_IR_USER:   dr_sh_d = USER_DIN;
            default:       dr_sh_d = '0;
          endcase
        end
        TPS_SHF_DR: begin
          case (ir_q)
            TPS_IR_IDCODE, TPS_IR_USER: begin
              dr_sh_d = {tdi_s2_q, dr_sh_q[31:1]};
            end
            default: dr_sh_d = {31'h0000_0000, tdi_s2_q};
          endcase
        end
        TPS_UPD_DR: begin
          if (ir_q == TPS_IR_USER) begin
            user_d = dr_sh_q;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge tap_rst) begin
    if (tap_rst) begin
      ir_sh_q <= TPS_IR_CAPT;
      ir_q    <= TPS_IR_IDCODE;
      dr_sh_q <= '0;
      user_q  <= TPS_USER_RST;
    end else begin
      ir_sh_q <= ir_sh_d;
      ir_q    <= ir_d;
      dr_sh_q <= dr_sh_d;
      user_q  <= user_d;
    end
  end

  // Controller select caught on test reset release
  always_comb begin
    sel_d = sel_q;
    if (trst_rel) begin
      sel_d = sel_s2_q;
    end
  end

  // Serial output only moves on test clock fall
  always_comb begin
    tdo_d    = tdo_q;
    tdo_oe_d = tdo_oe_q;
    if (tck_fall) begin
      if (!sel_q) begin
        tdo_d    = FACT_TDO;
        tdo_oe_d = 1'b1;
      end else if (state_q == TPS_SHF_IR) begin
        tdo_d    = ir_sh_q[0];
        tdo_oe_d = 1'b1;
      end else if (state_q == TPS_SHF_DR) begin
        tdo_d    = dr_sh_q[0];
        tdo_oe_d = 1'b1;
      end else begin
        tdo_oe_d = 1'b0;
      end
    end
  end

  // Shared pin carries return clock or single wire traffic
  always_comb begin
    if (RET_CLK_MODE) begin
      shr_o_d  = tck_s2_q;
      shr_oe_d = 1'b1;
      wrx_d    = 1'b1;
    end else begin
      shr_o_d  = WIRE_O;
      shr_oe_d = WIRE_OE;
      wrx_d    = shr_s2_q;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      sel_q    <= TPS_SEL_RST;
      tdo_q    <= 1'b0;
      shr_o_q  <= 1'b0;
      shr_oe_q <= 1'b0;
      wrx_q    <= 1'b1;
    end else begin
      sel_q    <= sel_d;
      tdo_q    <= tdo_d;
      shr_o_q  <= shr_o_d;
      shr_oe_q <= shr_oe_d;
      wrx_q    <= wrx_d;
    end
  end

  // Serial output released at once by either reset
  always_ff @(posedge CLK or posedge tap_rst) begin
    if (tap_rst) begin
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign TDO       = tdo_q;
  assign TDO_OE    = tdo_oe_q;
  assign SHARE_O   = shr_o_q;
  assign SHARE_OE  = shr_oe_q;
  assign WIRE_RX   = wrx_q;
  assign DBG_SEL   = sel_q;
  assign USER_DOUT = user_q;

  a_tap_held_reset: assert property (
    @(posedge CLK) disable iff (RST) !rel_q[1] |-> state_q == TPS_TLR)
    else $error("controller not held in reset");

  a_tdi_rise_capture: assert property (
    @(posedge CLK) disable iff (tap_rst)
    tck_rise && state_q == TPS_SHF_DR && ir_q == TPS_IR_BYPASS
    |=> dr_sh_q[0] == $past(tdi_s2_q))
    else $error("serial input not captured on rise");

  a_tdo_fall_only: assert property (
    @(posedge CLK) disable iff (RST)
    (tdo_q != $past(tdo_q)) |-> $past(tck_fall))
    else $error("serial output moved off a falling edge");

  a_tms_step_only: assert property (
    @(posedge CLK) disable iff (tap_rst)
    !tck_rise ##1 !tap_rst |-> $stable(state_q))
    else $error("state moved without a test clock rise");

  a_sel_latch_edge: assert property (
    @(posedge CLK) disable iff (RST)
    trst_rel |=> sel_q == $past(sel_s2_q))
    else $error("select not latched at reset release");

  a_sel_hold_between: assert property (
    @(posedge CLK) disable iff (RST)
    !trst_rel |=> $stable(sel_q))
    else $error("select changed outside reset release");

  a_ret_clk_pin: assert property (
    @(posedge CLK) disable iff (RST)
    RET_CLK_MODE |=> shr_oe_q && shr_o_q == $past(tck_s2_q) && wrx_q)
    else $error("return clock not on shared pin");

  a_oe_held_reset: assert property (
    @(posedge CLK) disable iff (RST) !rel_q[1] |-> !tdo_oe_q)
    else $error("serial output driven during test reset");

  a_ir_tlr_idcode: assert property (
    @(posedge CLK) disable iff (tap_rst)
    state_q == TPS_TLR ##1 !tap_rst |-> ir_q == TPS_IR_IDCODE)
    else $error("instruction not identity after logic reset");

endmodule

// >>> core/tps_pkg.sv
// Shared constants and types of the test port controller select block
package tps_pkg;

  localparam int          TPS_IR_LEN   = 4;
  localparam int          TPS_DR_LEN   = 32;
  localparam logic [3:0]  TPS_IR_EXTEST = 4'h0;
  localparam logic [3:0]  TPS_IR_IDCODE = 4'h1;
  localparam logic [3:0]  TPS_IR_USER   = 4'h8;
  localparam logic [3:0]  TPS_IR_BYPASS = 4'hF;
  localparam logic [3:0]  TPS_IR_CAPT   = 4'h1;
  // Identity value is arbitrary
  localparam logic [31:0] TPS_ID_DEF    = 32'h1000_0001;
  localparam logic [31:0] TPS_USER_RST  = 32'h0000_0000;
  localparam logic        TPS_SEL_RST   = 1'b1;

  typedef enum logic [3:0] {
    TPS_TLR     = 4'h0,
    TPS_IDLE    = 4'h1,
    TPS_SEL_DR  = 4'h3,
    TPS_CAP_DR  = 4'h2,
    TPS_SHF_DR  = 4'h6,
    TPS_EX1_DR  = 4'h7,
    TPS_PAU_DR  = 4'h5,
    TPS_EX2_DR  = 4'h4,
    TPS_UPD_DR  = 4'hC,
    TPS_SEL_IR  = 4'hD,
    TPS_CAP_IR  = 4'hF,
    TPS_SHF_IR  = 4'hE,
    TPS_EX1_IR  = 4'hA,
    TPS_PAU_IR  = 4'hB,
    TPS_EX2_IR  = 4'h9,
    TPS_UPD_IR  = 4'h8
  } tps_state_t;

endpackage

// >>> core/tps_tap_fsm.sv
// Test controller state machine stepped by sampled test clock rising edges
`timescale 1ns/1ps
module tps_tap_fsm
  import tps_pkg::*;
(
  input  logic       clk,
  input  logic       rst,
  input  logic       adv,
  input  logic       tms,
  output tps_state_t state_q
);

  tps_state_t state_d;

  function automatic tps_state_t tps_next(input tps_state_t s,
                                          input logic m);
    case (s)
      TPS_TLR:    tps_next = m ? TPS_TLR    : TPS_IDLE;
      TPS_IDLE:   tps_next = m ? TPS_SEL_DR : TPS_IDLE;
      TPS_SEL_DR: tps_next = m ? TPS_SEL_IR : TPS_CAP_DR;
      TPS_CAP_DR: tps_next = m ? TPS_EX1_DR : TPS_SHF_DR;
      TPS_SHF_DR: tps_next = m ? TPS_EX1_DR : TPS_SHF_DR;
      TPS_EX1_DR: tps_next = m ? TPS_UPD_DR : TPS_PAU_DR;
      TPS_PAU_DR: tps_next = m ? TPS_EX2_DR : TPS_PAU_DR;
      TPS_EX2_DR: tps_next = m ? TPS_UPD_DR : TPS_SHF_DR;
      TPS_UPD_DR: tps_next = m ? TPS_SEL_DR : TPS_IDLE;
      TPS_SEL_IR: tps_next = m ? TPS_TLR    : TPS_CAP_IR;
      TPS_CAP_IR: tps_next = m ? TPS_EX1_IR : TPS_SHF_IR;
      TPS_SHF_IR: tps_next = m ? TPS_EX1_IR : TPS_SHF_IR;
      TPS_EX1_IR: tps_next = m ? TPS_UPD_IR : TPS_PAU_IR;
      TPS_PAU_IR: tps_next = m ? TPS_EX2_IR : TPS_PAU_IR;
      TPS_EX2_IR: tps_next = m ? TPS_UPD_IR : TPS_SHF_IR;
      TPS_UPD_IR: tps_next = m ? TPS_SEL_DR : TPS_IDLE;
      default:    tps_next = TPS_TLR;
    endcase
  endfunction

  always_comb begin
    state_d = state_q;
    if (adv) begin
      state_d = tps_next(state_q, tms);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= TPS_TLR;
    end else begin
      state_q <= state_d;
    end
  end

endmodule

// >>> testbench/tps_host.sv
// Debugger host model driving the test port
`timescale 1ns/1ps
module tps_host (
  output logic tck,
  output logic tms,
  output logic tdi,
  output logic trst_n,
  output logic ctrl_sel,
  input  logic tdo
);
  int bad_edge = 0;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
    trst_n = 1'b0;
    ctrl_sel = 1'b1;
  end
  // One period; returns TDO as held before the rise
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #200;
    o = tdo;
    tck = 1'b1;
    #190;
    if (tdo !== o) bad_edge++;
    #10;
    tck = 1'b0;
  endtask
  // Reset the controller, select held across release
  task automatic tap_reset(input logic sel);
    logic o;
    ctrl_sel = sel;
    trst_n = 1'b0;
    #200;
    trst_n = 1'b1;
    #400;
    ctrl_sel = 1'b1;
    step(1'b0, 1'b0, o);
  endtask
  // Idle to Idle scan, LSB first
  task automatic scan(input logic ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout);
    logic o;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    dout = '0;
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule

// >>> testbench/tb.sv
// Self-checking bench of the test port
`timescale 1ns/1ps
module tb;
  import tps_pkg::*;
  logic        CLK, RST, TCK, TMS, TDI, TRST_N, CTRL_SEL, FACT_TDO;
  logic        RET_CLK_MODE, WIRE_O, WIRE_OE, SHARE_I, TDO, TDO_OE;
  logic        SHARE_O, SHARE_OE, WIRE_RX, DBG_SEL, o;
  logic [31:0] USER_DIN, USER_DOUT, v;
  int          errors = 0;
  int          samples_checked = 0;
  tps_host host (.tck(TCK), .tms(TMS), .tdi(TDI), .trst_n(TRST_N),
                 .ctrl_sel(CTRL_SEL), .tdo(TDO));
  tps_port DUT (.CLK(CLK), .RST(RST), .TCK(TCK), .TMS(TMS), .TDI(TDI),
    .TRST_N(TRST_N), .CTRL_SEL(CTRL_SEL), .FACT_TDO(FACT_TDO),
    .RET_CLK_MODE(RET_CLK_MODE), .WIRE_O(WIRE_O), .WIRE_OE(WIRE_OE),
    .SHARE_I(SHARE_I), .USER_DIN(USER_DIN), .TDO(TDO), .TDO_OE(TDO_OE),
    .SHARE_O(SHARE_O), .SHARE_OE(SHARE_OE), .WIRE_RX(WIRE_RX),
    .DBG_SEL(DBG_SEL), .USER_DOUT(USER_DOUT));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic t_id;
    host.tap_reset(1'b1);
    host.scan(1'b0, 32, 32'h0, v);
    chk(v, TPS_ID_DEF);
    $display("id test done");
  endtask
  task automatic t_user;
    USER_DIN = 32'hA5C3_0F96;
    host.scan(1'b1, 4, {28'h0, TPS_IR_USER}, v);
    chk(v, {28'h0, TPS_IR_CAPT});
    host.scan(1'b0, 32, 32'h1234_5678, v);
    chk(v, 32'hA5C3_0F96);
    chk(USER_DOUT, 32'h1234_5678);
    $display("user test done");
  endtask
  task automatic t_bypass;
    logic [3:0] codes [3];
    codes = '{TPS_IR_BYPASS, TPS_IR_EXTEST, 4'h3};
    foreach (codes[i]) begin
      host.scan(1'b1, 4, {28'h0, codes[i]}, v);
      host.scan(1'b0, 8, 32'hB5, v);
      chk(v, 32'h6A);
    end
    $display("bypass test done");
  endtask
  task automatic t_trst;
    host.scan(1'b1, 4, {28'h0, TPS_IR_USER}, v);
    host.step(1'b1, 1'b0, o);
    host.step(1'b0, 1'b0, o);
    host.step(1'b0, 1'b0, o);
    host.step(1'b0, 1'b1, o);
    chk(TDO_OE, 1'b1);
    host.trst_n = 1'b0;
    wait_clk(2);
    chk(TDO_OE, 1'b0);
    host.tap_reset(1'b1);
    host.scan(1'b0, 32, 32'h0, v);
    chk(v, TPS_ID_DEF);
    $display("test reset test done");
  endtask
  task automatic t_factory;
    host.tap_reset(1'b0);
    chk(DBG_SEL, 1'b0);
    FACT_TDO = 1'b1;
    host.step(1'b1, 1'b0, o);
    host.step(1'b1, 1'b0, o);
    chk({TDO_OE, o}, 2'b11);
    FACT_TDO = 1'b0;
    host.step(1'b1, 1'b0, o);
    host.step(1'b1, 1'b0, o);
    chk(o, 1'b0);
    host.tap_reset(1'b1);
    chk(DBG_SEL, 1'b1);
    $display("select test done");
  endtask
  task automatic t_share;
    RET_CLK_MODE = 1'b1;
    WIRE_O = 1'b1;
    SHARE_I = 1'b0;
    host.tck = 1'b1;
    wait_clk(5);
    chk({SHARE_O, SHARE_OE, WIRE_RX}, 3'b111);
    host.tck = 1'b0;
    wait_clk(5);
    chk({SHARE_O, SHARE_OE, WIRE_RX}, 3'b011);
    RET_CLK_MODE = 1'b0;
    WIRE_O = 1'b1;
    WIRE_OE = 1'b1;
    SHARE_I = 1'b0;
    wait_clk(5);
    chk({SHARE_O, SHARE_OE, WIRE_RX}, 3'b110);
    WIRE_OE = 1'b0;
    SHARE_I = 1'b1;
    wait_clk(5);
    chk({SHARE_OE, WIRE_RX}, 2'b01);
    $display("shared pin test done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    stop_test();
  end
  initial begin
    RST = 1'b1;
    FACT_TDO = 1'b0;
    RET_CLK_MODE = 1'b0;
    WIRE_O = 1'b0;
    WIRE_OE = 1'b0;
    SHARE_I = 1'b1;
    USER_DIN = 32'h0;
    wait_clk(3);
    RST = 1'b0;
    wait_clk(6);
    t_id();
    t_user();
    t_bypass();
    t_trst();
    t_factory();
    t_share();
    chk(host.bad_edge, 0);
    stop_test();
  end
endmodule
